// File: inc/cri_params.svh
/*
 Constants of the CAN register access interpreter: message layout, ranges, error codes.
 Assumes 11-bit identifiers and a byte-wide payload with byte 0 sent first.
*/
`ifndef CRI_PARAMS_SVH
`define CRI_PARAMS_SVH
`define CRI_ID_W 11
`define CRI_QRY_OFS 11'h001
`define CRI_ANS_OFS 11'h002
`define CRI_FULL_CODE 16'hCCCC
`define CRI_ZERO_CODE 16'h0000
`define CRI_QUANT_MASK 16'hFFFE
`define CRI_ERR_REG 16'hFFFF
`define CRI_MARK_FIRST 8'hFF
`define CRI_CNT_MAX 8'h7B
`define CRI_SEG_DEPTH 64
`define CRI_SINGLE_DLC 4'h5
`define CRI_MULTI_DLC 4'h8
`define CRI_ANS_DLC 4'h4
`define CRI_ERR_DLC 4'h3
`define CRI_SETVAL_LO 16'h01F4
`define CRI_SETVAL_HI 16'h01F7
`define CRI_ERR_ADDR 8'h02
`define CRI_ERR_VALUE 8'h03
`define CRI_ERR_STATE 8'h04
`define CRI_ERR_SHORT 8'h05
`define CRI_ERR_SEQ 8'h06
`endif

// File: inc/cri_pkg.sv
/*
 Types shared by the interpreter and its testbench.
 Assumes cri_params.svh is included by every user.
*/
package cri_pkg;
  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [7:0][7:0] data;
  } cri_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COMMIT,
    ST_QWAIT,
    ST_TX
  } cri_state_t;
endpackage

// File: hw/cri_seg_store.sv
/*
 Segment store for split register writes, one 32-bit word per marker slot.
 Assumes the writer gives a slot index already derived from the marker.
*/
`timescale 1ns/1ps
`include "cri_params.svh"
module cri_seg_store (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [5:0] wr_idx,
  input wire logic [31:0] wr_word,
  input wire logic [5:0] rd_idx,
  output logic [31:0] rd_word
);
  logic [31:0] mem [`CRI_SEG_DEPTH];

  // Slot chosen by marker, so arrival order does not matter
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wr_idx] <= wr_word;
    end
  end

  // Read is combinational so the commit walk needs no extra wait
  assign rd_word = mem[rd_idx];
endmodule

// File: hw/cri_top.sv
/*
 CAN register access interpreter: decodes write and query frames, drives register port, sends answers.
 Assumes a CAN controller that hands over whole frames and takes one answer frame at a time.
*/
`timescale 1ns/1ps
`include "cri_params.svh"
module cri_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [10:0] base_id,
  input wire logic [10:0] bcast_id,
  input wire logic remote_granted,
  input wire logic rx_valid,
  input wire cri_pkg::cri_frame_t rx_frame,
  output logic rx_ready_q,
  output logic wr_valid_q,
  output logic [15:0] wr_reg_q,
  output logic [15:0] wr_data_q,
  output logic rd_req_q,
  output logic [15:0] rd_reg_q,
  input wire logic rd_ack,
  input wire logic [15:0] rd_data,
  output logic tx_valid_q,
  output cri_pkg::cri_frame_t tx_q,
  input wire logic tx_ready
);
  cri_pkg::cri_state_t st_q, st_d;
  logic rx_ready_d, wr_valid_d, rd_req_d, tx_valid_d;
  logic [15:0] wr_reg_d, wr_data_d, rd_reg_d;
  cri_pkg::cri_frame_t tx_d;
  logic act_q, act_d;
  logic [15:0] start_q, start_d;
  logic [7:0] cnt_q, cnt_d;
  logic [63:0] mask_q, mask_d;
  logic [6:0] idx_q, idx_d;
  logic seg_we;
  logic [5:0] seg_idx;
  logic [31:0] seg_rd;

  // Identifier arithmetic wraps inside 11 bits
  function automatic logic [10:0] id_plus(input logic [10:0] b, input logic [10:0] k);
    id_plus = 11'(b + k);
  endfunction

  function automatic logic is_setval(input logic [15:0] r);
    is_setval = (r >= `CRI_SETVAL_LO) && (r <= `CRI_SETVAL_HI);
  endfunction

  // True when a multi write range touches any set value register
  function automatic logic span_setval(input logic [15:0] s, input logic [7:0] n);
    logic [16:0] last;
    last = 17'(s) + 17'(n) - 17'h00001;
    span_setval = (s <= `CRI_SETVAL_HI) && (last >= 17'(`CRI_SETVAL_LO));
  endfunction

  // Full scale clamp plus coarser output step, for set value registers only
  function automatic logic [15:0] adj_val(input logic [15:0] r, input logic [15:0] v);
    logic [15:0] c;
    c = (v > `CRI_FULL_CODE) ? `CRI_FULL_CODE : v;
    adj_val = is_setval(r) ? (c & `CRI_QUANT_MASK) : v;
  endfunction

  // Segments needed for a register count, two registers per segment
  function automatic logic [63:0] need_mask(input logic [7:0] n);
    logic [6:0] segs;
    segs = 7'((9'(n) + 9'h001) >> 1);
    need_mask = (64'h1 << segs) - 64'h1;
  endfunction

  function automatic cri_pkg::cri_frame_t err_frame(input logic [10:0] b, input logic [7:0] code);
    cri_pkg::cri_frame_t f;
    f = '0;
    f.id = id_plus(b, `CRI_ANS_OFS);
    f.dlc = `CRI_ERR_DLC;
    f.data[0] = 8'(`CRI_ERR_REG >> 8);
    f.data[1] = 8'(`CRI_ERR_REG & 16'h00FF);
    f.data[2] = code;
    err_frame = f;
  endfunction

  // Frame decode shared by the state logic and the checks
  logic rx_take, rx_wr, rx_qry;
  logic [15:0] rx_reg, rx_val;
  logic [7:0] rx_cnt, rx_mark, rx_slot;
  assign rx_take = rx_valid && rx_ready_q;
  assign rx_wr = (rx_frame.id == base_id) || (rx_frame.id == bcast_id);
  assign rx_qry = (rx_frame.id == id_plus(base_id, `CRI_QRY_OFS)) && (rx_frame.id != bcast_id);
  assign rx_reg = {rx_frame.data[0], rx_frame.data[1]};
  assign rx_cnt = rx_frame.data[2];
  assign rx_mark = rx_frame.data[3];
  assign rx_slot = 8'(`CRI_MARK_FIRST - rx_mark);
  assign rx_val = {rx_frame.data[3], rx_frame.data[4]};

  assign seg_idx = (st_q == cri_pkg::ST_COMMIT) ? idx_q[6:1] : rx_slot[5:0];

  cri_seg_store u_store (
    .clk_sys(clk_sys),
    .we(seg_we),
    .wr_idx(seg_idx),
    .wr_word({rx_frame.data[4], rx_frame.data[5], rx_frame.data[6], rx_frame.data[7]}),
    .rd_idx(seg_idx),
    .rd_word(seg_rd)
  );

  // Next values of the interpreter
  always_comb begin
    logic [63:0] nm;
    nm = need_mask(rx_cnt);
    st_d = st_q;
    wr_valid_d = 1'b0;
    wr_reg_d = wr_reg_q;
    wr_data_d = wr_data_q;
    rd_req_d = 1'b0;
    rd_reg_d = rd_reg_q;
    tx_valid_d = tx_valid_q;
    tx_d = tx_q;
    act_d = act_q;
    start_d = start_q;
    cnt_d = cnt_q;
    mask_d = mask_q;
    idx_d = idx_q;
    seg_we = 1'b0;
    unique case (st_q)
      cri_pkg::ST_IDLE: begin
        if (rx_take && rx_wr) begin
          if (rx_cnt == 8'h01) begin
            // Single write; set values guarded by remote state and range
            if (rx_frame.dlc < `CRI_SINGLE_DLC) begin
              tx_d = err_frame(base_id, `CRI_ERR_SHORT);
              st_d = cri_pkg::ST_TX;
            end else if (is_setval(rx_reg) && !remote_granted) begin
              tx_d = err_frame(base_id, `CRI_ERR_STATE);
              st_d = cri_pkg::ST_TX;
            end else if (is_setval(rx_reg) && rx_val > `CRI_FULL_CODE) begin
              tx_d = err_frame(base_id, `CRI_ERR_VALUE);
              st_d = cri_pkg::ST_TX;
            end else begin
              wr_valid_d = 1'b1;
              wr_reg_d = rx_reg;
              wr_data_d = adj_val(rx_reg, rx_val);
            end
          end else if (rx_cnt >= 8'h02 && rx_cnt <= `CRI_CNT_MAX) begin
            if (rx_frame.dlc < `CRI_MULTI_DLC) begin
              tx_d = err_frame(base_id, `CRI_ERR_SHORT);
              st_d = cri_pkg::ST_TX;
              act_d = 1'b0;
            end else if (rx_slot > 8'h3F || !nm[rx_slot[5:0]]) begin
              // Marker past the declared count
              tx_d = err_frame(base_id, `CRI_ERR_SEQ);
              st_d = cri_pkg::ST_TX;
              act_d = 1'b0;
            end else if (act_q && rx_reg == start_q && rx_cnt == cnt_q
                         && !(rx_mark == `CRI_MARK_FIRST && mask_q[0])) begin
              // Joins the open transfer; the first segment may arrive late
              mask_d = mask_q | (64'h1 << rx_slot[5:0]);
              seg_we = 1'b1;
            end else if (rx_mark == `CRI_MARK_FIRST || !act_q) begin
              // A fresh transfer drops any unfinished one
              act_d = 1'b1;
              start_d = rx_reg;
              cnt_d = rx_cnt;
              mask_d = 64'h1 << rx_slot[5:0];
              seg_we = 1'b1;
            end else begin
              // Offset start or other count inside an open transfer
              tx_d = err_frame(base_id, `CRI_ERR_SEQ);
              st_d = cri_pkg::ST_TX;
              act_d = 1'b0;
            end
            // Commit only once every needed slot has arrived
            if (act_d && ((mask_d & need_mask(cnt_d)) == need_mask(cnt_d))) begin
              act_d = 1'b0;
              if (span_setval(start_d, cnt_d) && !remote_granted) begin
                tx_d = err_frame(base_id, `CRI_ERR_STATE);
                st_d = cri_pkg::ST_TX;
              end else begin
                idx_d = 7'h00;
                st_d = cri_pkg::ST_COMMIT;
              end
            end
          end else begin
            tx_d = err_frame(base_id, `CRI_ERR_VALUE);
            st_d = cri_pkg::ST_TX;
          end
        end else if (rx_take && rx_qry) begin
          rd_req_d = 1'b1;
          rd_reg_d = rx_reg;
          st_d = cri_pkg::ST_QWAIT;
        end
      end
      cri_pkg::ST_COMMIT: begin
        // One register per cycle, even index in the upper half
        wr_valid_d = 1'b1;
        wr_reg_d = 16'(start_q + 16'(idx_q));
        wr_data_d = adj_val(wr_reg_d, idx_q[0] ? seg_rd[15:0] : seg_rd[31:16]);
        idx_d = 7'(idx_q + 7'h01);
        if (8'(idx_q) == 8'(cnt_q - 8'h01)) begin
          st_d = cri_pkg::ST_IDLE;
        end
      end
      cri_pkg::ST_QWAIT: begin
        // Register file latency is open ended
        if (rd_ack) begin
          tx_d = '0;
          tx_d.id = id_plus(base_id, `CRI_ANS_OFS);
          tx_d.dlc = `CRI_ANS_DLC;
          tx_d.data[0] = rd_reg_q[15:8];
          tx_d.data[1] = rd_reg_q[7:0];
          tx_d.data[2] = rd_data[15:8];
          tx_d.data[3] = rd_data[7:0];
          st_d = cri_pkg::ST_TX;
        end
      end
      cri_pkg::ST_TX: begin
        if (tx_ready && tx_valid_q) begin
          tx_valid_d = 1'b0;
          st_d = cri_pkg::ST_IDLE;
        end
      end
    endcase
    if (st_q != cri_pkg::ST_TX && st_d == cri_pkg::ST_TX) begin
      tx_valid_d = 1'b1;
    end
    // Frames are refused while busy, so nothing is half taken
    rx_ready_d = (st_d == cri_pkg::ST_IDLE);
  end

  // Registering of all state and outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= cri_pkg::ST_IDLE;
      rx_ready_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_reg_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      rd_req_q <= 1'b0;
      rd_reg_q <= 16'h0000;
      tx_valid_q <= 1'b0;
      tx_q <= '0;
      act_q <= 1'b0;
      start_q <= 16'h0000;
      cnt_q <= 8'h00;
      mask_q <= 64'h0;
      idx_q <= 7'h00;
    end else begin
      st_q <= st_d;
      rx_ready_q <= rx_ready_d;
      wr_valid_q <= wr_valid_d;
      wr_reg_q <= wr_reg_d;
      wr_data_q <= wr_data_d;
      rd_req_q <= rd_req_d;
      rd_reg_q <= rd_reg_d;
      tx_valid_q <= tx_valid_d;
      tx_q <= tx_d;
      act_q <= act_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      mask_q <= mask_d;
      idx_q <= idx_d;
    end
  end

  // Checks on the driven side
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_answer_id: assert property (tx_valid_q |-> tx_q.id == id_plus(base_id, `CRI_ANS_OFS))
    else $error("answer not on base plus two");
  a_setval_range: assert property (wr_valid_q && is_setval(wr_reg_q) |-> wr_data_q <= `CRI_FULL_CODE)
    else $error("set value above full scale");
  a_setval_quant: assert property (wr_valid_q && is_setval(wr_reg_q) |-> !wr_data_q[0])
    else $error("set value not quantised");
  a_remote_gate: assert property (rx_take && rx_wr && rx_cnt == 8'h01 && is_setval(rx_reg) && !remote_granted
      && rx_frame.dlc >= `CRI_SINGLE_DLC |=> !wr_valid_q && tx_valid_q && tx_q.data[2] == `CRI_ERR_STATE)
    else $error("set value written without remote");
  a_bcast_query: assert property (rx_take && rx_frame.id == bcast_id |=> !rd_req_q)
    else $error("broadcast frame raised a query");
  a_query_req: assert property (rx_take && rx_qry |=> rd_req_q && rd_reg_q == $past(rx_reg))
    else $error("query register not forwarded");
  a_single_write: assert property (rx_take && rx_wr && rx_cnt == 8'h01 && !is_setval(rx_reg)
      && rx_frame.dlc >= `CRI_SINGLE_DLC |=> wr_valid_q && wr_reg_q == $past(rx_reg) && wr_data_q == $past(rx_val))
    else $error("single write not applied");
  a_slot_range: assert property (rx_take && rx_wr && rx_cnt >= 8'h02 && rx_cnt <= `CRI_CNT_MAX
      && rx_frame.dlc >= `CRI_MULTI_DLC && {rx_slot, 1'b0} >= 9'(rx_cnt)
      |=> tx_valid_q && {tx_q.data[0], tx_q.data[1]} == `CRI_ERR_REG && tx_q.data[2] == `CRI_ERR_SEQ)
    else $error("segment past the count not refused");
  // A segment ahead of its first one must open the transfer, not fail
  a_late_first: assert property (rx_take && rx_wr && rx_cnt >= 8'h02 && rx_cnt <= `CRI_CNT_MAX
      && rx_frame.dlc >= `CRI_MULTI_DLC && rx_mark != `CRI_MARK_FIRST && !act_q && {rx_slot, 1'b0} < 9'(rx_cnt)
      |=> act_q && !tx_valid_q)
    else $error("early segment refused");
  a_err_dlc: assert property (tx_valid_q && {tx_q.data[0], tx_q.data[1]} == `CRI_ERR_REG
      |-> tx_q.dlc == `CRI_ERR_DLC)
    else $error("error answer length wrong");
  a_tx_hold: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_q))
    else $error("answer dropped before taken");
  a_query_answer: assert property (st_q == cri_pkg::ST_QWAIT && rd_ack
      |=> tx_valid_q && tx_q.dlc == `CRI_ANS_DLC && {tx_q.data[2], tx_q.data[3]} == $past(rd_data))
    else $error("query answer data wrong");
  a_commit_walk: assert property (st_q == cri_pkg::ST_COMMIT |=> wr_valid_q
      && wr_reg_q == 16'($past(start_q) + 16'($past(idx_q))))
    else $error("commit register walk wrong");
endmodule

// File: bench/cri_host_model.sv
/*
 Host side model: takes answer frames and serves register reads.
 Assumes the answer and read ports of cri_top, one clock.
*/
`timescale 1ns/1ps
module cri_host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] slow,
  input wire logic tx_valid_q,
  output logic tx_ready,
  input wire logic rd_req_q,
  input wire logic [15:0] rd_reg_q,
  output logic rd_ack,
  output logic [15:0] rd_data
);
  logic [3:0] tx_cnt;
  logic [3:0] rd_cnt;
  logic rd_busy;
  logic [15:0] rd_val;
  // Answers are taken asked or not, after a settable stall
  always @(posedge clk_sys) begin
    if (!rst_n || !tx_valid_q || tx_ready) begin
      tx_cnt <= 4'h0;
      tx_ready <= 1'b0;
    end else begin
      tx_cnt <= tx_cnt + 4'h1;
      tx_ready <= (tx_cnt >= slow);
    end
  end
  // Reads answer after the stall; stale data is inverted so it never looks valid
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_busy <= 1'b0;
      rd_ack <= 1'b0;
      rd_cnt <= 4'h0;
      rd_data <= 16'h0000;
    end else if (rd_req_q) begin
      rd_busy <= 1'b1;
      rd_cnt <= 4'h0;
      rd_val <= rd_reg_q ^ 16'hA5A5;
    end else if (rd_busy && rd_cnt >= slow) begin
      rd_busy <= 1'b0;
      rd_ack <= 1'b1;
      rd_data <= rd_val;
    end else begin
      rd_cnt <= rd_cnt + 4'h1;
      rd_ack <= 1'b0;
      if (rd_ack) rd_data <= ~rd_data;
    end
  end
endmodule

// File: bench/testbench.sv
/*
 Self-checking bench for cri_top with a host model on the answer side.
 Assumes cri_params.svh and cri_pkg are compiled first.
*/
`timescale 1ns/1ps
`include "cri_params.svh"
module testbench;
  logic clk_sys, rst_n, remote_granted, rx_valid, rx_ready_q, wr_valid_q;
  logic rd_req_q, rd_ack, tx_valid_q, tx_ready;
  logic [10:0] base_id, bcast_id;
  logic [15:0] wr_reg_q, wr_data_q, rd_reg_q, rd_data;
  logic [3:0] slow;
  cri_pkg::cri_frame_t rx_frame, tx_q;
  cri_pkg::cri_frame_t tq[$];
  logic [31:0] wq[$];
  int num_errors = 0;
  int compares = 0;
  cri_top i_cri_top (.clk_sys(clk_sys), .rst_n(rst_n), .base_id(base_id), .bcast_id(bcast_id),
    .remote_granted(remote_granted), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready_q(rx_ready_q),
    .wr_valid_q(wr_valid_q), .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q), .rd_req_q(rd_req_q),
    .rd_reg_q(rd_reg_q), .rd_ack(rd_ack), .rd_data(rd_data), .tx_valid_q(tx_valid_q), .tx_q(tx_q),
    .tx_ready(tx_ready));
  cri_host_model i_cri_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .tx_valid_q(tx_valid_q),
    .tx_ready(tx_ready), .rd_req_q(rd_req_q), .rd_reg_q(rd_reg_q), .rd_ack(rd_ack), .rd_data(rd_data));
  // Clock of 8 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Log every write pulse and every answer handed over
  always @(posedge clk_sys) begin
    if (wr_valid_q === 1'b1) wq.push_back({wr_reg_q, wr_data_q});
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) tq.push_back(tx_q);
  end
  function automatic cri_pkg::cri_frame_t mk(input logic [10:0] id, input logic [3:0] dlc,
    input logic [15:0] rg, input logic [7:0] b2, input logic [39:0] rest);
    cri_pkg::cri_frame_t f;
    f.id = id;
    f.dlc = dlc;
    f.data[0] = rg[15:8];
    f.data[1] = rg[7:0];
    f.data[2] = b2;
    for (int i = 3; i < 8; i++) f.data[i] = rest[63-8*i -: 8];
    return f;
  endfunction
  function automatic cri_pkg::cri_frame_t errf(input logic [7:0] code);
    return mk(base_id + `CRI_ANS_OFS, `CRI_ERR_DLC, `CRI_ERR_REG, code, 40'h0);
  endfunction
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("mismatch %s expected done seen timeout", what);
    final_report();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bytes past the length code are free on the wire, so they are not judged
  task automatic chk_tx(input cri_pkg::cri_frame_t exp, input cri_pkg::cri_frame_t got);
    for (int i = 0; i < 8; i++) if (i >= exp.dlc) got.data[i] = exp.data[i];
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch answer frame expected %h seen %h", exp, got);
    end
  endtask
  // Offer one frame and hold it until the edge that takes it
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] rg,
    input logic [7:0] b2, input logic [39:0] rest);
    int k;
    @(posedge clk_sys);
    rx_frame <= mk(id, dlc, rg, b2, rest);
    rx_valid <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      if (rx_ready_q === 1'b1) break;
    end
    rx_valid <= 1'b0;
    if (k == 200) timeout("frame take");
  endtask
  task automatic get_wr(input logic [31:0] exp);
    int k;
    for (k = 0; k < 200 && wq.size() == 0; k++) @(posedge clk_sys);
    if (k == 200) timeout("register write");
    chk("register write", exp, wq.pop_front());
  endtask
  task automatic get_tx(input cri_pkg::cri_frame_t exp);
    int k;
    for (k = 0; k < 200 && tq.size() == 0; k++) @(posedge clk_sys);
    if (k == 200) timeout("answer frame");
    chk_tx(exp, tq.pop_front());
  endtask
  // Nothing further may come out after a scenario
  task automatic done(input string name);
    repeat (20) @(posedge clk_sys);
    chk("stray writes", 32'h0, 32'(wq.size()));
    chk("stray answers", 32'h0, 32'(tq.size()));
    wq.delete();
    tq.delete();
    $display("test %s finished", name);
  endtask
  task automatic t_single();
    send(base_id, 4'h5, 16'h0123, 8'h01, {16'hBEEF, 24'h0});
    get_wr({16'h0123, 16'hBEEF});
    send(bcast_id, 4'h5, 16'h0124, 8'h01, {16'h1234, 24'h0});
    get_wr({16'h0124, 16'h1234});
    send(base_id, 4'h3, 16'h0010, 8'h01, 40'h0);
    get_tx(errf(`CRI_ERR_SHORT));
    done("single");
  endtask
  // Set values: refused without remote, range limit, quantisation
  task automatic t_setval();
    logic [15:0] v [4] = '{16'h1000, 16'hCCCD, 16'hCCCC, 16'h0001};
    logic [7:0] e [4] = '{`CRI_ERR_STATE, `CRI_ERR_VALUE, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      remote_granted <= (i != 0);
      send(base_id, 4'h5, 16'h01F4 + 16'(i), 8'h01, {v[i], 24'h0});
      if (e[i] != 8'h00) get_tx(errf(e[i]));
      else get_wr({16'h01F4 + 16'(i), v[i] & 16'hFFFE});
    end
    done("setval");
  endtask
  // Queries follow the base identifier, with a quick and a slow host
  task automatic t_query();
    logic [10:0] b [2] = '{11'h200, 11'h120};
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      base_id <= b[i];
      slow <= (i == 0) ? 4'h3 : 4'h0;
      d = 16'h01FB ^ 16'hA5A5;
      send(b[i] + `CRI_QRY_OFS, 4'h2, 16'h01FB, 8'h00, 40'h0);
      get_tx(mk(b[i] + `CRI_ANS_OFS, `CRI_ANS_DLC, 16'h01FB, d[15:8], {d[7:0], 32'h0}));
    end
    done("query");
  endtask
  // Segments out of order; odd count drops the last half word
  task automatic t_multi();
    send(base_id, 4'h8, 16'h0010, 8'h03, {8'hFE, 32'h3333_9999});
    send(base_id, 4'h8, 16'h0010, 8'h03, {8'hFF, 32'h1111_2222});
    get_wr({16'h0010, 16'h1111});
    get_wr({16'h0011, 16'h2222});
    get_wr({16'h0012, 16'h3333});
    done("multi");
  endtask
  // New first segment drops the open transfer; markers past the count and offset segments refused
  task automatic t_restart();
    send(base_id, 4'h8, 16'h0020, 8'h04, {8'hFF, 32'hAAAA_BBBB});
    send(base_id, 4'h8, 16'h0030, 8'h02, {8'hFF, 32'h5555_6666});
    get_wr({16'h0030, 16'h5555});
    get_wr({16'h0031, 16'h6666});
    send(base_id, 4'h8, 16'h0020, 8'h04, {8'hFD, 32'hCCCC_DDDD});
    get_tx(errf(`CRI_ERR_SEQ));
    send(base_id, 4'h8, 16'h0040, 8'h04, {8'hFF, 32'h0101_0202});
    send(base_id, 4'h8, 16'h0041, 8'h04, {8'hFE, 32'h0303_0404});
    get_tx(errf(`CRI_ERR_SEQ));
    done("restart");
  endtask
  // Multi writes: clamp of set values, bad count, short frame, set values without remote
  task automatic t_refuse();
    send(base_id, 4'h8, 16'h01F7, 8'h02, {8'hFF, 32'hFFFF_0003});
    get_wr({16'h01F7, `CRI_FULL_CODE});
    get_wr({16'h01F8, 16'h0003});
    @(posedge clk_sys);
    remote_granted <= 1'b0;
    send(base_id, 4'h8, 16'h0050, 8'h7C, {8'hFF, 32'h0});
    get_tx(errf(`CRI_ERR_VALUE));
    send(base_id, 4'h7, 16'h0050, 8'h02, {8'hFF, 32'h0});
    get_tx(errf(`CRI_ERR_SHORT));
    send(base_id, 4'h8, 16'h01F3, 8'h02, {8'hFF, 32'h1111_2222});
    get_tx(errf(`CRI_ERR_STATE));
    done("refuse");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    remote_granted = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
    base_id = 11'h120;
    bcast_id = 11'h300;
    slow = 4'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_single();
    t_setval();
    t_query();
    t_multi();
    t_restart();
    t_refuse();
    final_report();
  end
endmodule
